/* tbp_pkg.sv */
// Purpose: Constants for the timer based pulse width output block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Byte offsets chosen for this block
package tbp_pkg;
	localparam logic [7:0] ADDR_TIME_BASE_COUNT     = 8'h00;
	localparam logic [7:0] ADDR_TIME_BASE_PERIOD    = 8'h04;
	localparam logic [7:0] ADDR_TIME_BASE_CONTROL   = 8'h08;
	localparam logic [7:0] ADDR_DUTY_LOW_BYTE_ONE   = 8'h0C;
	localparam logic [7:0] ADDR_DUTY_SHADOW_BYTE    = 8'h10;
	localparam logic [7:0] ADDR_MODULE_CONTROL_ONE  = 8'h14;
	localparam logic [7:0] ADDR_PORT_C_DIRECTION    = 8'h18;
	localparam logic [7:0] ADDR_GENERAL_PORT_C      = 8'h1C;
	localparam logic [7:0] ADDR_MATCH_FLAG          = 8'h20;
	localparam logic [7:0] RESET_TIME_BASE_PERIOD   = 8'hFF;
	localparam logic [7:0] RESET_PORT_C_DIRECTION   = 8'hFF;
	localparam logic [7:0] RESET_ZERO               = 8'h00;
	localparam int         PIN_BIT                  = 2;
	localparam int         CTRL_ENABLE_BIT          = 2;
	localparam int         CTRL_POST_LSB            = 3;
	localparam int         MODE_DUTY_LSB            = 4;
	localparam int         MODE_PWM_LSB             = 2;
	localparam logic [1:0] MODE_PWM_CODE            = 2'h3;
	localparam logic [1:0] PRESCALE_DIV1            = 2'h0;
	localparam logic [1:0] PRESCALE_DIV4            = 2'h1;
	localparam int         OSC_PER_INSTR            = 4;
	localparam int         DIVIDE_MAX               = 16;
endpackage

/* tbp_prescaler.sv */
// Purpose: Prescaler giving time base ticks and two low duty bits
// Assumes: Four clk_sys edges form one instruction cycle
// Notes: Divides by 1, 4 or 16
`timescale 1ns/100ps
`default_nettype none
module tbp_prescaler (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       enable,
	input  wire logic [1:0] select,
	output logic            tick,
	output logic [1:0]      low_bits
);
	logic [5:0] count;
	logic [5:0] span;
	always_comb begin
		if (select == tbp_pkg::PRESCALE_DIV1) begin
			span = 6'(tbp_pkg::OSC_PER_INSTR);
		end else if (select == tbp_pkg::PRESCALE_DIV4) begin
			span = 6'(tbp_pkg::OSC_PER_INSTR * 4);
		end else begin
			span = 6'(tbp_pkg::OSC_PER_INSTR * tbp_pkg::DIVIDE_MAX);
		end
	end
	// Quarter phase or upper prescaler bits extend the count
	always_comb begin
		if (select == tbp_pkg::PRESCALE_DIV1) begin
			low_bits = count[1:0];
		end else if (select == tbp_pkg::PRESCALE_DIV4) begin
			low_bits = count[3:2];
		end else begin
			low_bits = count[5:4];
		end
	end
	assign tick = enable && (count == span - 6'h01);
	always_ff @(posedge clk_sys) begin
		if (reset || !enable || tick) begin
			count <= 6'h00;
		end else begin
			count <= count + 6'h01;
		end
	end
endmodule
`default_nettype wire

/* tbp_postscaler.sv */
// Purpose: Postscaler that divides time base matches into a flag
// Assumes: Match pulses last one cycle
// Notes: Flag does not touch the waveform
`timescale 1ns/100ps
`default_nettype none
module tbp_postscaler (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       match,
	input  wire logic [3:0] select,
	input  wire logic       clear,
	output logic            flag
);
	logic [3:0] count;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			count <= 4'h0;
		end else if (match) begin
			count <= (count == select) ? 4'h0 : count + 4'h1;
		end
	end
	// Set wins over clear
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			flag <= 1'b0;
		end else if (match && count == select) begin
			flag <= 1'b1;
		end else if (clear) begin
			flag <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* tbp_pwm.sv */
// Purpose: Timer based ten bit pulse width output with APB registers
// Assumes: APB master per protocol, pins synchronous to clk_sys
// Notes: Zero wait state slave, no error answers
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module tbp_pwm (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             pwm_output_pin,
	output logic             pwm_output_enable
);
	logic [7:0] time_base_count;
	logic [7:0] time_base_period;
	logic [7:0] time_base_control;
	logic [7:0] duty_low_byte_one;
	logic [7:0] duty_shadow_byte_one;
	logic [7:0] module_control_one;
	logic [7:0] port_c_direction;
	logic [7:0] general_port_c;
	logic [1:0] duty_latch;
	logic       modulation_latch;
	logic       tick;
	logic [1:0] low_bits;
	logic       period_end;
	logic       pwm_mode;
	logic       match_flag;
	logic       wr;
	logic       rd;
	logic [7:0] next_count;
	logic [9:0] buffered_duty;
	logic [9:0] extended_count;
	logic       clear_match;
	logic       period_start;
	logic       pin_value;

	function automatic logic mode_is_pwm(input logic [7:0] ctrl);
		return ctrl[tbp_pkg::MODE_PWM_LSB +: 2] == tbp_pkg::MODE_PWM_CODE;
	endfunction

	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign pwm_mode = mode_is_pwm(module_control_one);
	assign period_end = tick && (time_base_count == time_base_period);
	assign buffered_duty = {duty_shadow_byte_one, duty_latch};
	assign extended_count = {time_base_count, low_bits};
	assign clear_match = buffered_duty == extended_count;

	tbp_prescaler u_prescaler (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.enable   (time_base_control[tbp_pkg::CTRL_ENABLE_BIT]),
		.select   (time_base_control[1:0]),
		.tick     (tick),
		.low_bits (low_bits)
	);

	tbp_postscaler u_postscaler (
		.clk_sys (clk_sys),
		.reset   (reset),
		.match   (period_end),
		.select  (time_base_control[tbp_pkg::CTRL_POST_LSB +: 4]),
		.clear   (wr && paddr == tbp_pkg::ADDR_MATCH_FLAG && !pwdata[0]),
		.flag    (match_flag)
	);

	always_comb begin
		if (period_end) begin
			next_count = tbp_pkg::RESET_ZERO;
		end else if (tick) begin
			next_count = time_base_count + 8'h01;
		end else begin
			next_count = time_base_count;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			time_base_count <= tbp_pkg::RESET_ZERO;
		end else if (wr && paddr == tbp_pkg::ADDR_TIME_BASE_COUNT) begin
			time_base_count <= pwdata[7:0];
		end else begin
			time_base_count <= next_count;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			time_base_period   <= tbp_pkg::RESET_TIME_BASE_PERIOD;
			time_base_control  <= tbp_pkg::RESET_ZERO;
			duty_low_byte_one  <= tbp_pkg::RESET_ZERO;
			module_control_one <= tbp_pkg::RESET_ZERO;
			port_c_direction   <= tbp_pkg::RESET_PORT_C_DIRECTION;
			general_port_c     <= tbp_pkg::RESET_ZERO;
		end else if (wr) begin
			case (paddr)
				tbp_pkg::ADDR_TIME_BASE_PERIOD: begin
					time_base_period <= pwdata[7:0];
				end
				tbp_pkg::ADDR_TIME_BASE_CONTROL: begin
					time_base_control <= {1'b0, pwdata[6:0]};
				end
				tbp_pkg::ADDR_DUTY_LOW_BYTE_ONE: begin
					duty_low_byte_one <= pwdata[7:0];
				end
				tbp_pkg::ADDR_MODULE_CONTROL_ONE: begin
					module_control_one <= {2'h0, pwdata[5:0]};
				end
				tbp_pkg::ADDR_PORT_C_DIRECTION: begin
					port_c_direction <= pwdata[7:0];
				end
				tbp_pkg::ADDR_GENERAL_PORT_C: begin
					general_port_c <= pwdata[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Shadow byte writable only outside modulation mode
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			duty_shadow_byte_one <= tbp_pkg::RESET_ZERO;
			duty_latch           <= 2'h0;
		end else if (pwm_mode && period_end) begin
			duty_shadow_byte_one <= duty_low_byte_one;
			duty_latch <= module_control_one[tbp_pkg::MODE_DUTY_LSB +: 2];
		end else if (!pwm_mode && wr && paddr == tbp_pkg::ADDR_DUTY_SHADOW_BYTE) begin
			duty_shadow_byte_one <= pwdata[7:0];
		end
	end

	// Set one cycle after the period end so the registered clear lands on the match
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			period_start <= 1'b0;
		end else begin
			period_start <= period_end;
		end
	end

	// Internal output latch
	always_ff @(posedge clk_sys) begin
		if (reset || !pwm_mode) begin
			modulation_latch <= 1'b0;
		end else if (period_start) begin
			modulation_latch <= buffered_duty != 10'h000;
		end else if (clear_match) begin
			modulation_latch <= 1'b0;
		end
	end

	always_comb begin
		if (pwm_mode) begin
			pin_value = modulation_latch;
		end else begin
			pin_value = general_port_c[tbp_pkg::PIN_BIT];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pwm_output_pin    <= 1'b0;
			pwm_output_enable <= 1'b0;
		end else begin
			pwm_output_pin    <= pin_value;
			pwm_output_enable <= !port_c_direction[tbp_pkg::PIN_BIT];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (rd) begin
			case (paddr)
				tbp_pkg::ADDR_TIME_BASE_COUNT:    prdata <= {24'h0, time_base_count};
				tbp_pkg::ADDR_TIME_BASE_PERIOD:   prdata <= {24'h0, time_base_period};
				tbp_pkg::ADDR_TIME_BASE_CONTROL:  prdata <= {24'h0, time_base_control};
				tbp_pkg::ADDR_DUTY_LOW_BYTE_ONE:  prdata <= {24'h0, duty_low_byte_one};
				tbp_pkg::ADDR_DUTY_SHADOW_BYTE:   prdata <= {24'h0, duty_shadow_byte_one};
				tbp_pkg::ADDR_MODULE_CONTROL_ONE: prdata <= {24'h0, module_control_one};
				tbp_pkg::ADDR_PORT_C_DIRECTION:   prdata <= {24'h0, port_c_direction};
				tbp_pkg::ADDR_GENERAL_PORT_C:     prdata <= {24'h0, general_port_c};
				tbp_pkg::ADDR_MATCH_FLAG:         prdata <= {31'h0, match_flag};
				default:                          prdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* tbp_pwm_monitor.sv */
// Purpose: Port checker for the pulse width output block
// Assumes: Sees only the top module ports
// Notes: Bound to tbp_pwm below
`timescale 1ns/100ps
`default_nettype none
module tbp_pwm_monitor (
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        pwm_output_pin,
	input wire logic        pwm_output_enable
);
	logic dir_bit;
	assign dir_bit = pwdata[tbp_pkg::PIN_BIT];
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence dir_wr_s;
		psel && penable && pready && pwrite && paddr == tbp_pkg::ADDR_PORT_C_DIRECTION;
	endsequence
	chk_ready_setup: assert property (setup_s |=> pready) else $error("no pready after setup");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	chk_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
	chk_no_error: assert property (pready |-> !pslverr) else $error("pslverr raised");
	chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000) else $error("upper bits set");
	chk_unmapped_zero: assert property (setup_s ##0 (!pwrite && paddr == 8'h24) |=> prdata == 32'h00000000)
		else $error("unmapped read not zero");
	chk_enable_dir: assert property (dir_wr_s |=> ##1 pwm_output_enable == !$past(dir_bit, 2))
		else $error("enable does not follow direction");
	chk_reset_quiet: assert property (disable iff (1'b0) reset |=> !pready && !pwm_output_pin && !pwm_output_enable)
		else $error("outputs active in reset");
endmodule
bind tbp_pwm tbp_pwm_monitor mon_u (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pwm_output_pin(pwm_output_pin), .pwm_output_enable(pwm_output_enable));
`default_nettype wire

/* tb_top.sv */
// Purpose: Self checking bench for the pulse width output block
// Assumes: Zero wait APB slave
// Notes: Reads checked from a queue
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        clk_sys     = 1'b0;
	logic        reset       = 1'b1;
	logic        psel        = 1'b0;
	logic        penable     = 1'b0;
	logic        pwrite      = 1'b0;
	logic [7:0]  paddr       = 8'h00;
	logic [31:0] pwdata      = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pin;
	logic        pin_oe;
	logic [31:0] exp_q[$];
	int          miscompares = 0;
	int          tests_run   = 0;
	int          cycles      = 0;
	int          seed        = 32'h5555;
	always #2 clk_sys = ~clk_sys;
	tbp_pwm dut_u (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
		.pwm_output_pin(pin), .pwm_output_enable(pin_oe));
	task automatic complete_run();
		$display("miscompares %0d tests_run %0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h00000000);
	endtask
	task automatic meas(input int eh, input int ep);
		int h;
		h = 0;
		while (pin !== 1'b0) @(posedge clk_sys);
		while (pin !== 1'b1) @(posedge clk_sys);
		while (pin === 1'b1) begin
			h++;
			@(posedge clk_sys);
		end
		cmp("high time", 32'(eh), 32'(h));
		while (pin === 1'b0) begin
			h++;
			@(posedge clk_sys);
		end
		cmp("period", 32'(ep), 32'(h));
	endtask
	task automatic win(input int e);
		int h;
		h = 0;
		repeat (64) begin
			@(posedge clk_sys);
			h += int'(pin === 1'b1);
		end
		cmp("high count", 32'(e), 32'(h));
	endtask
	task automatic setup(input logic [7:0] per, input logic [9:0] duty, input logic [1:0] pre);
		apb(1'b1, tbp_pkg::ADDR_TIME_BASE_CONTROL, 32'h00000000);
		apb(1'b1, tbp_pkg::ADDR_TIME_BASE_COUNT, 32'h00000000);
		apb(1'b1, tbp_pkg::ADDR_TIME_BASE_PERIOD, {24'h000000, per});
		apb(1'b1, tbp_pkg::ADDR_DUTY_LOW_BYTE_ONE, {24'h000000, duty[9:2]});
		apb(1'b1, tbp_pkg::ADDR_PORT_C_DIRECTION, 32'h000000FB);
		apb(1'b1, tbp_pkg::ADDR_TIME_BASE_CONTROL, {25'h0, 4'($random(seed)), 1'b1, pre});
		apb(1'b1, tbp_pkg::ADDR_MODULE_CONTROL_ONE, {26'h0, duty[1:0], 2'h3, 2'($random(seed))});
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			cmp("prdata", exp_q.pop_front(), prdata);
		end
		if (cycles == 30000) begin
			miscompares++;
			complete_run();
		end
	end
	initial begin
		logic [7:0] per;
		logic [9:0] duty;
		int         f;
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rd(tbp_pkg::ADDR_TIME_BASE_PERIOD, 32'h000000FF);
		rd(tbp_pkg::ADDR_PORT_C_DIRECTION, 32'h000000FF);
		rd(tbp_pkg::ADDR_MODULE_CONTROL_ONE, 32'h00000000);
		rd(8'h24, 32'h00000000);
		for (int i = 0; i < 3; i++) begin
			f = 1 << (2 * i);
			per = 8'(3 + $unsigned($random(seed)) % 8);
			duty = 10'(4 + $unsigned($random(seed)) % ((per + 1) * 4 - 4));
			setup(per, duty, 2'(i));
			while (pin !== 1'b1) @(posedge clk_sys);
			meas(duty * f, (per + 1) * 4 * f);
			cmp("output enable", 32'h00000001, {31'h0, pin_oe});
		end
		fork
			meas(duty * 16, (per + 1) * 64);
			begin
				while (pin !== 1'b0) @(posedge clk_sys);
				while (pin !== 1'b1) @(posedge clk_sys);
				apb(1'b1, tbp_pkg::ADDR_MODULE_CONTROL_ONE, {26'h0, ~duty[1:0], 4'hC});
			end
		join
		meas((duty ^ 10'h3) * 16, (per + 1) * 64);
		apb(1'b1, tbp_pkg::ADDR_DUTY_SHADOW_BYTE, 32'h000000FF);
		rd(tbp_pkg::ADDR_DUTY_SHADOW_BYTE, {24'h000000, duty[9:2]});
		setup(8'h03, 10'h3FF, 2'h0);
		repeat (40) @(posedge clk_sys);
		win(64);
		apb(1'b1, tbp_pkg::ADDR_GENERAL_PORT_C, 32'h00000000);
		apb(1'b1, tbp_pkg::ADDR_MODULE_CONTROL_ONE, 32'h00000000);
		win(64 - 64);
		setup(8'h03, 10'h000, 2'h0);
		repeat (40) @(posedge clk_sys);
		win(0);
		complete_run();
	end
endmodule
`default_nettype wire
